// *** verilog/rcbms_top.sv ***
// reset, clock and boot mode selection of the processor
// Overview of operation
// [R1] processor cycle runs at twice input clock
// [R2] clock output at cycle rate, disable bit
// [R3] input clock kept running by source
// [R4] reset held low 2000 input clocks
// [R5] later resets keep internal clock running
// [R6] reset empties stacks, masks interrupts, clears status
// [R7] boot only without bus request, boot straps
// [R8] after boot fetch internal address zero
// [R9] memory mode strap latched, pin becomes flag
// [R10] byte dma boot loads 32 words
// [R11] no boot, run external address zero
// [R12] host dma boot until address zero written
// [R13] host mode offers lowest address bit only
// [R14] strap d low drives acknowledge actively
// [R15] strap d high acknowledge open drain
// [R16] strap driver released after reset
// [R17] second serial port may become interrupts
// [R18] interrupts globally enabled out of reset
// [R19] only the six strap settings used
// [R20] straps sampled at reset release, then held
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rcbms_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic board_reset_n,
  input wire logic mode_a_pin,
  input wire logic mode_b_pin,
  input wire logic mode_d_pin,
  input wire logic programmable_flag_two_in,
  output logic programmable_flag_two_out,
  output logic programmable_flag_two_oe,
  input wire logic bus_request,
  input wire logic byte_dma_word_done,
  input wire logic host_pm_write,
  input wire logic [13:0] host_pm_addr,
  input wire logic host_ack_n,
  input wire logic core_address_bit,
  output logic host_lowest_address_bit,
  output logic host_access_acknowledge_out,
  output logic host_access_acknowledge_oe,
  input wire logic [rcbms_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rcbms_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rcbms_pkg::DATA_W-1:0] reg_rdata,
  output logic cycle_rate_clock_output,
  output logic input_clock_phase,
  output logic clock_stable,
  output logic master_reset,
  output logic stacks_clear,
  output logic core_run,
  output logic [13:0] fetch_addr,
  output logic fetch_external,
  output logic host_mode,
  output logic byte_dma_boot_req,
  output logic host_dma_enable,
  output logic second_port_as_irq,
  output logic [9:0] int_mask,
  output logic global_int_enable,
  output logic [6:0] mode_status_register
);
  // ==========================================================
  // board reset synchroniser
  logic rst_sync_a;
  logic rst_sync_b;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_sync_a <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_sync_a <= board_reset_n;
      rst_sync_b <= rst_sync_a;
    end
  end
  // [R4] master reset also held until lock completes
  assign master_reset = srst | ~rst_sync_b | ~clock_stable;
  // [R6] stacks held empty during reset
  assign stacks_clear = master_reset;
  // ==========================================================
  // register bus view
  rcbms_pkg::rcbms_bus_s bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  wire wr_control = bus.wr & (bus.addr == rcbms_pkg::OFS_CONTROL);
  wire wr_mode_status_register = bus.wr & (bus.addr == rcbms_pkg::OFS_MODE_STATUS);
  wire wr_mask = bus.wr & (bus.addr == rcbms_pkg::OFS_INT_MASK);
  wire wr_ictl = bus.wr & (bus.addr == rcbms_pkg::OFS_INT_CTRL);
  logic [3:0] control;
  wire clock_output_disable_bit = control[rcbms_pkg::CTL_CLK_DIS];
  // ==========================================================
  // clock output and lock timer
  rcbms_clkgen u_clkgen (
    .ref_clk(ref_clk),
    .srst(srst),
    .clock_output_disable_bit(clock_output_disable_bit),
    .cycle_rate_clock_output(cycle_rate_clock_output),
    .input_clock_phase(input_clock_phase),
    .clock_stable(clock_stable)
  );
  // ==========================================================
  // strap capture
  rcbms_pkg::rcbms_strap_s strap_pin;
  rcbms_pkg::rcbms_strap_s strap;
  logic release_pulse;
  assign strap_pin = '{d: mode_d_pin, c: programmable_flag_two_in,
                       b: mode_b_pin, a: mode_a_pin};
  rcbms_strap_latch u_strap (
    .ref_clk(ref_clk),
    .srst(srst),
    .strap_pin(strap_pin),
    .master_reset(master_reset),
    .strap_latched(strap),
    .release_pulse(release_pulse)
  );
  // ==========================================================
  // strap decode
  rcbms_pkg::rcbms_boot_e boot_sel;
  // [R10] byte dma boot in full or host mode
  wire sel_byte = ~strap.a & ~strap.b;
  // [R12] host dma boot
  wire sel_host = strap.c & ~strap.b & strap.a;
  // [R11] no boot, full memory mode
  wire sel_none = ~strap.c & strap.b & ~strap.a;
  // [R19] other strap settings fall back to no boot
  assign boot_sel = sel_byte ? rcbms_pkg::BOOT_BYTE_DMA :
                    sel_host ? rcbms_pkg::BOOT_HOST_DMA :
                    rcbms_pkg::BOOT_NONE;
  // [R9] memory mode from latched strap c
  assign host_mode = strap.c;
  // ==========================================================
  // boot sequencer
  typedef enum logic [2:0] {
    ST_RESET,
    ST_WAIT_BUS,
    ST_BYTE_BOOT,
    ST_HOST_BOOT,
    ST_RUN
  } rcbms_state_e;
  rcbms_state_e state;
  rcbms_state_e next_state;
  logic [5:0] word_cnt;
  logic run_external;
  wire host_zero_hit = host_pm_write &
                       (host_pm_addr == rcbms_pkg::HOST_RELEASE_ADDR);
  wire last_word = byte_dma_word_done &
                   (word_cnt == rcbms_pkg::BOOT_WORDS - 6'h01);
  wire boot_wanted = (boot_sel != rcbms_pkg::BOOT_NONE);
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET: begin
        if (release_pulse) begin
          next_state = ST_WAIT_BUS;
        end
      end
      // [R7] boot only when no bus request pending
      ST_WAIT_BUS: begin
        if (!boot_wanted) begin
          next_state = ST_RUN;
        end else if (!bus_request) begin
          next_state = (boot_sel == rcbms_pkg::BOOT_BYTE_DMA) ?
                       ST_BYTE_BOOT : ST_HOST_BOOT;
        end
      end
      // [R10] hold execution until 32 words loaded
      ST_BYTE_BOOT: begin
        if (last_word) begin
          next_state = ST_RUN;
        end
      end
      // [R12] hold until program address zero written
      ST_HOST_BOOT: begin
        if (host_zero_hit) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (master_reset) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (master_reset || state != ST_BYTE_BOOT) begin
      word_cnt <= '0;
    end else if (byte_dma_word_done) begin
      word_cnt <= word_cnt + 6'h01;
    end
  end
  // [R11] external start only when no boot selected
  always_ff @(posedge ref_clk) begin
    if (master_reset) begin
      run_external <= 1'b0;
    end else if (state == ST_WAIT_BUS) begin
      run_external <= ~boot_wanted;
    end
  end
  assign core_run = (state == ST_RUN);
  // [R8] first fetch at address zero, internal after boot
  assign fetch_addr = rcbms_pkg::START_ADDR;
  assign fetch_external = run_external;
  assign byte_dma_boot_req = (state == ST_BYTE_BOOT);
  assign host_dma_enable = host_mode & ~master_reset;
  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (master_reset) begin
      control <= rcbms_pkg::CONTROL_RST;
      // [R6] status cleared, all interrupts masked
      mode_status_register <= rcbms_pkg::MODE_STATUS_RST;
      int_mask <= rcbms_pkg::INT_MASK_RST;
      // [R18] servicing enabled out of reset
      global_int_enable <= rcbms_pkg::GLOBAL_INT_RST;
    end else begin
      if (wr_control) begin
        control <= bus.wdata[3:0];
      end
      if (wr_mode_status_register) begin
        mode_status_register <= bus.wdata[6:0];
      end
      if (wr_mask) begin
        int_mask <= bus.wdata[9:0];
      end
      if (wr_ictl) begin
        global_int_enable <= bus.wdata[0];
      end
    end
  end
  // [R17] serial port or two extra interrupts
  assign second_port_as_irq = control[rcbms_pkg::CTL_PORT_AS_IRQ];
  // ==========================================================
  // read back
  logic [rcbms_pkg::DATA_W-1:0] rd_mux;
  // flag pin level passes two flip-flops before the status view
  logic flag_sync_a;
  logic flag_sync_b;
  always_ff @(posedge ref_clk) begin
    flag_sync_a <= programmable_flag_two_in;
    flag_sync_b <= flag_sync_a;
  end
  wire [rcbms_pkg::DATA_W-1:0] status_word = {
    5'h00, flag_sync_b, clock_stable, core_run,
    fetch_external, state, strap};
  always_comb begin
    unique case (bus.addr)
      rcbms_pkg::OFS_CONTROL: rd_mux = {12'h000, control};
      rcbms_pkg::OFS_MODE_STATUS: rd_mux = {9'h000, mode_status_register};
      rcbms_pkg::OFS_INT_MASK: rd_mux = {6'h00, int_mask};
      rcbms_pkg::OFS_INT_CTRL: rd_mux = {15'h0000, global_int_enable};
      rcbms_pkg::OFS_STATUS: rd_mux = status_word;
      default: rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (bus.rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
  // ==========================================================
  // pins
  // [R16] flag pin is an input during reset so the strap driver owns it
  assign programmable_flag_two_out = control[rcbms_pkg::CTL_FLAG_OUT];
  assign programmable_flag_two_oe = ~master_reset &
                                    control[rcbms_pkg::CTL_FLAG_DIR];
  // [R13] lowest address bit only in host mode
  assign host_lowest_address_bit = host_mode & core_address_bit;
  // [R14] strap d low drives both levels
  // [R15] strap d high: release for low, board pull-down
  assign host_access_acknowledge_out = strap.d ? 1'b1 : host_ack_n;
  assign host_access_acknowledge_oe = host_mode & ~master_reset &
                                      (~strap.d | host_ack_n);
endmodule : rcbms_top
`default_nettype wire

// *** verilog/rcbms_pkg.sv ***
// constants and carrier types of the reset, clock and boot mode block
package rcbms_pkg;
  // ==========================================================
  // timing
  localparam int unsigned REF_CLK_MHZ = 50;
  localparam int unsigned LOCK_IN_CYCLES = 2000;
  // one input clock cycle spans two processor cycles
  localparam int unsigned LOCK_CYCLES = LOCK_IN_CYCLES * 2;
  localparam int unsigned LOCK_W = 13;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);
  // ==========================================================
  // boot
  localparam logic [5:0] BOOT_WORDS = 6'h20;
  localparam logic [13:0] START_ADDR = 14'h0000;
  localparam logic [13:0] HOST_RELEASE_ADDR = 14'h0000;
  // ==========================================================
  // register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_INT_CTRL = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam int unsigned CTL_CLK_DIS = 0;
  localparam int unsigned CTL_PORT_AS_IRQ = 1;
  localparam int unsigned CTL_FLAG_OUT = 2;
  localparam int unsigned CTL_FLAG_DIR = 3;
  localparam logic [3:0] CONTROL_RST = 4'h0;
  localparam logic [6:0] MODE_STATUS_RST = 7'h00;
  localparam logic [9:0] INT_MASK_RST = 10'h000;
  localparam logic GLOBAL_INT_RST = 1'b1;
  // ==========================================================
  // types
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } rcbms_strap_s;
  localparam rcbms_strap_s STRAP_RST = 4'h0;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rcbms_bus_s;
  typedef enum logic [1:0] {
    BOOT_NONE,
    BOOT_BYTE_DMA,
    BOOT_HOST_DMA
  } rcbms_boot_e;
endpackage : rcbms_pkg

// *** verilog/rcbms_strap_latch.sv ***
// strap synchroniser and latch at reset release
`timescale 1ns/10ps
`default_nettype none
module rcbms_strap_latch (
  input wire logic ref_clk,
  input wire logic srst,
  input wire rcbms_pkg::rcbms_strap_s strap_pin,
  input wire logic master_reset,
  output rcbms_pkg::rcbms_strap_s strap_latched,
  output logic release_pulse
);
  // ==========================================================
  // two-stage synchroniser
  rcbms_pkg::rcbms_strap_s sync_a;
  rcbms_pkg::rcbms_strap_s sync_b;
  logic reset_seen;
  wire release_edge = reset_seen & ~master_reset;
  always_ff @(posedge ref_clk) begin
    sync_a <= strap_pin;
    sync_b <= sync_a;
  end
  // ==========================================================
  // [R20] latch on release
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      strap_latched <= rcbms_pkg::STRAP_RST;
      reset_seen <= 1'b1;
      release_pulse <= 1'b0;
    end else begin
      reset_seen <= master_reset;
      release_pulse <= release_edge;
      // [R9] memory mode caught here
      if (release_edge) begin
        strap_latched <= sync_b;
      end
    end
  end
endmodule : rcbms_strap_latch
`default_nettype wire

// *** verilog/rcbms_clkgen.sv ***
// cycle-rate clock output and power-up lock timer
`timescale 1ns/10ps
`default_nettype none
module rcbms_clkgen (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clock_output_disable_bit,
  output logic cycle_rate_clock_output,
  output logic input_clock_phase,
  output logic clock_stable
);
  logic [rcbms_pkg::LOCK_W-1:0] lock_cnt;
  // ==========================================================
  // [R1] two processor cycles per input clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      input_clock_phase <= 1'b0;
      cycle_rate_clock_output <= 1'b0;
    end else begin
      input_clock_phase <= ~input_clock_phase;
      // [R2] gated clock output
      cycle_rate_clock_output <= clock_output_disable_bit ? 1'b0 :
                                 ~cycle_rate_clock_output;
    end
  end
  // ==========================================================
  // [R5] lock counted once, later resets keep clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lock_cnt <= '0;
      clock_stable <= 1'b0;
    end else if (!clock_stable) begin
      lock_cnt <= lock_cnt + 1'b1;
      clock_stable <= (lock_cnt == rcbms_pkg::LOCK_LAST);
    end
  end
endmodule : rcbms_clkgen
`default_nettype wire

// *** verif/rcbms_checker_assertions.sv ***
// concurrent checks on the reset, clock and boot mode block
`timescale 1ns/10ps
`default_nettype none
module rcbms_checker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic master_reset,
  input wire logic stacks_clear,
  input wire logic [9:0] int_mask,
  input wire logic [6:0] mode_status_register,
  input wire logic global_int_enable,
  input wire logic clock_stable,
  input wire logic input_clock_phase,
  input wire logic cycle_rate_clock_output,
  input wire logic core_address_bit,
  input wire logic host_mode,
  input wire logic host_lowest_address_bit,
  input wire logic host_access_acknowledge_oe,
  input wire logic host_access_acknowledge_out,
  input wire logic host_ack_n,
  input wire logic [13:0] fetch_addr,
  input wire logic core_run,
  input wire logic byte_dma_boot_req,
  input wire logic byte_dma_word_done,
  input wire logic bus_request
);
  // ======
  // boot words seen while the byte boot runs
  logic [6:0] words;
  always_ff @(posedge ref_clk) begin
    if (srst || master_reset) begin
      words <= 7'h00;
    end else if (byte_dma_boot_req && byte_dma_word_done) begin
      words <= words + 7'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  phase_tick_a: assert property (
    !$past(srst) |-> input_clock_phase != $past(input_clock_phase))
    else $error("input clock phase stuck");
  clk_out_a: assert property (
    cycle_rate_clock_output |=> !cycle_rate_clock_output)
    else $error("clock output not at cycle rate");
  lock_hold_a: assert property (!clock_stable |-> master_reset)
    else $error("reset left before clock lock");
  clk_keep_a: assert property (clock_stable |=> clock_stable)
    else $error("clock lost after lock");
  reset_clear_a: assert property (
    master_reset |-> stacks_clear ##1 (int_mask == 10'h000 &&
    mode_status_register == 7'h00 && global_int_enable))
    else $error("master reset state wrong");
  boot_gate_a: assert property (
    $rose(byte_dma_boot_req) |-> !$past(bus_request))
    else $error("boot began under bus request");
  fetch_zero_a: assert property (fetch_addr == 14'h0000)
    else $error("first fetch not at zero");
  word_count_a: assert property (
    $rose(core_run) && $past(byte_dma_boot_req) |-> words == 7'h20)
    else $error("run before all boot words");
  addr_bit_a: assert property (
    host_lowest_address_bit == (core_address_bit && host_mode))
    else $error("lowest address bit wrong");
  ack_drive_a: assert property (
    host_access_acknowledge_oe && !host_access_acknowledge_out |->
    host_mode && !host_ack_n)
    else $error("acknowledge driven low wrongly");
  ack_idle_a: assert property (
    host_access_acknowledge_oe |-> host_mode && !master_reset)
    else $error("acknowledge driven outside host mode");
  strap_hold_a: assert property (
    !master_reset && !$past(master_reset) && !$past(master_reset, 2) &&
    !$past(master_reset, 3) |-> $stable(host_mode))
    else $error("latched mode changed");
  cover property ($rose(core_run) && $past(byte_dma_boot_req));
  cover property ($rose(core_run) && host_mode);
  cover property (host_access_acknowledge_oe && !host_access_acknowledge_out);
endmodule : rcbms_checker
bind rcbms_top rcbms_checker i_chk (.ref_clk, .srst, .master_reset,
  .stacks_clear, .int_mask, .mode_status_register, .global_int_enable,
  .clock_stable, .input_clock_phase, .cycle_rate_clock_output,
  .core_address_bit, .host_mode, .host_lowest_address_bit,
  .host_access_acknowledge_oe, .host_access_acknowledge_out, .host_ack_n,
  .fetch_addr, .core_run, .byte_dma_boot_req, .byte_dma_word_done,
  .bus_request);
`default_nettype wire

// *** verif/rcbms_board.sv ***
// board model: reset source, mode straps and boot host
`timescale 1ns/10ps
`default_nettype none
module rcbms_board (
  input wire logic ref_clk,
  input wire logic programmable_flag_two_out,
  input wire logic programmable_flag_two_oe,
  output logic board_reset_n,
  output rcbms_pkg::rcbms_strap_s st,
  output logic programmable_flag_two_in,
  output logic byte_dma_word_done,
  output logic host_pm_write,
  output logic [13:0] host_pm_addr
);
  // ======
  // pull resistor only
  assign programmable_flag_two_in = programmable_flag_two_oe ?
    programmable_flag_two_out : st.c;
  initial begin
    board_reset_n = 1'b1;
    st = 4'h0;
    byte_dma_word_done = 1'b0;
    host_pm_write = 1'b0;
    host_pm_addr = 14'h3FFF;
  end
  task reset_with(input rcbms_pkg::rcbms_strap_s s);
    @(posedge ref_clk);
    board_reset_n <= 1'b0;
    st <= s;
    repeat (6) @(posedge ref_clk);
    board_reset_n <= 1'b1;
  endtask : reset_with
  task words(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      byte_dma_word_done <= 1'b1;
    end
    @(posedge ref_clk);
    byte_dma_word_done <= 1'b0;
  endtask : words
  task host_wr(input logic [13:0] a);
    @(posedge ref_clk);
    host_pm_write <= 1'b1;
    host_pm_addr <= a;
    @(posedge ref_clk);
    host_pm_write <= 1'b0;
    host_pm_addr <= ~a;
  endtask : host_wr
endmodule : rcbms_board
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench of the reset, clock and boot mode block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk, srst, board_reset_n, bus_request, host_ack_n, c0;
  logic programmable_flag_two_in, programmable_flag_two_out;
  logic programmable_flag_two_oe, byte_dma_word_done, host_pm_write;
  logic core_address_bit, host_lowest_address_bit, rd_d;
  logic host_access_acknowledge_out, host_access_acknowledge_oe;
  logic reg_wr, reg_rd, cycle_rate_clock_output, clock_stable;
  logic master_reset, core_run, fetch_external, host_mode;
  logic byte_dma_boot_req, second_port_as_irq;
  logic [13:0] host_pm_addr;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, r;
  logic [15:0] exp_q[$];
  rcbms_pkg::rcbms_strap_s st, s;
  rcbms_pkg::rcbms_strap_s modes [6] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'hC, 4'hD};
  int seed = 95591, err_count = 0, checks_done = 0, cyc = 0, i, k;
  wire ack_pin = host_access_acknowledge_oe & host_access_acknowledge_out;
  rcbms_top i_dut (.ref_clk, .srst, .board_reset_n, .mode_a_pin(st.a),
    .mode_b_pin(st.b), .mode_d_pin(st.d), .programmable_flag_two_in,
    .programmable_flag_two_out, .programmable_flag_two_oe, .bus_request,
    .byte_dma_word_done, .host_pm_write, .host_pm_addr, .host_ack_n,
    .core_address_bit, .host_lowest_address_bit, .reg_addr, .reg_wdata,
    .host_access_acknowledge_out, .host_access_acknowledge_oe, .reg_wr,
    .reg_rd, .reg_rdata, .cycle_rate_clock_output, .input_clock_phase(),
    .clock_stable, .master_reset, .stacks_clear(), .core_run,
    .fetch_addr(), .fetch_external, .host_mode, .byte_dma_boot_req,
    .host_dma_enable(), .second_port_as_irq, .int_mask(),
    .global_int_enable(), .mode_status_register());
  rcbms_board brd (.ref_clk, .board_reset_n, .st, .programmable_flag_two_in,
    .programmable_flag_two_out, .programmable_flag_two_oe,
    .byte_dma_word_done, .host_pm_write, .host_pm_addr);
  // ======
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task stop_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    cyc++;
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front());
    end
    rd_d <= reg_rd;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // input clock kept running for the whole run
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    srst = 1'b1;
    bus_request = 1'b0;
    core_address_bit = 1'b0;
    host_ack_n = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    rd_d = 1'b0;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    wr(rcbms_pkg::OFS_INT_MASK, 16'h03FF);
    @(negedge ref_clk);
    chk(16'(master_reset), 16'h0001);
    k = 0;
    while (clock_stable !== 1'b1 && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
    rd(rcbms_pkg::OFS_INT_MASK, 16'h0000);
    rd(4'hF, 16'h0000);
    for (i = 0; i < 6; i++) begin
      s = modes[i];
      s.d = s.c ? s.d : 1'($random(seed));
      bus_request <= 1'b1;
      host_ack_n <= 1'($random(seed));
      core_address_bit <= 1'($random(seed));
      brd.reset_with(s);
      @(negedge ref_clk);
      chk(16'(clock_stable), 16'h0001);
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(16'(byte_dma_boot_req), 16'h0000);
      rd(rcbms_pkg::OFS_INT_MASK, 16'h0000);
      rd(rcbms_pkg::OFS_INT_CTRL, 16'h0001);
      rd(rcbms_pkg::OFS_MODE_STATUS, 16'h0000);
      bus_request <= 1'b0;
      repeat (3) @(posedge ref_clk);
      if (!s.b && s.a) begin
        brd.words(32);
        brd.host_wr(14'h0005);
        @(negedge ref_clk);
        chk(16'(core_run), 16'h0000);
        brd.host_wr(14'h0000);
      end else if (!s.b) begin
        brd.words(31);
        @(negedge ref_clk);
        chk(16'(core_run), 16'h0000);
        brd.words(1);
      end
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(16'(core_run), 16'h0001);
      chk(16'(host_mode), 16'(s.c));
      chk(16'(host_lowest_address_bit), 16'(core_address_bit & s.c));
      chk(16'(ack_pin), 16'(s.c & host_ack_n));
      rd(rcbms_pkg::OFS_STATUS, {5'h00, s.c, 2'b11, s.b, 3'h4, s});
      r = {12'h000, 1'b1, ~s.c, 2'($random(seed))};
      wr(rcbms_pkg::OFS_CONTROL, r);
      wr(rcbms_pkg::OFS_INT_MASK, 16'hFFFF);
      wr(rcbms_pkg::OFS_INT_CTRL, 16'h0000);
      rd(rcbms_pkg::OFS_INT_MASK, 16'h03FF);
      rd(rcbms_pkg::OFS_STATUS, {5'h00, ~s.c, 2'b11, s.b, 3'h4, s});
      rd(rcbms_pkg::OFS_CONTROL, r);
      @(negedge ref_clk);
      c0 = cycle_rate_clock_output;
      chk(16'(second_port_as_irq), 16'(r[1]));
      @(negedge ref_clk);
      chk(16'(cycle_rate_clock_output), r[0] ? 16'h0000 : 16'(!c0));
    end
    repeat (3) @(posedge ref_clk);
    stop_test();
  end
endmodule : tb
`default_nettype wire
